// ### pkg/ncr_pkg.sv
package ncr_pkg;
    // ----------------------------------------------------------------
    // Port addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_UPPER = 16'hBC72;
    localparam logic [15:0] ADDR_LOWER = 16'hB472;
    localparam logic [15:0] ADDR_MASK = 16'hC472;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BND_LSB = 4;
    localparam int SREF_BIT = 3;
    localparam int GATE_BIT = 2;
    localparam int PEND_BIT = 1;
    localparam int SNOOP_BIT = 0;
    localparam int CDRV_LSB = 10;
    localparam int MASK_W = 10;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] BND_RST = 12'h000;
    localparam logic [9:0] MASK_RST = 10'h000;
    localparam logic [1:0] CDRV_RST = 2'h0;
    localparam logic [1:0] CDRV_DEFAULT = 2'h0;

    // ----------------------------------------------------------------
    // Fixed regions, 4 KB page numbers A23:12; mask blocks as 16 KB block numbers A19:14
    // ----------------------------------------------------------------
    localparam logic [11:0] VMEM_LO = 12'h0A0;
    localparam logic [11:0] VMEM_HI = 12'h0BF;
    localparam logic [11:0] VBIOS_LO_C = 12'h0C0;
    localparam logic [11:0] VBIOS_HI_C = 12'h0C7;
    localparam logic [11:0] VBIOS_LO_E = 12'h0E0;
    localparam logic [11:0] VBIOS_HI_E = 12'h0EF;
    localparam logic [11:0] SBIOS_LO = 12'h0F0;
    localparam logic [11:0] SBIOS_HI = 12'h0FF;
    localparam logic [5:0] MASK_BLK_FIRST = 6'h32;
    localparam logic [5:0] MASK_BLK_LAST = 6'h3B;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int REFRESH_NS = 15600;
    localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
    localparam int SLOW_REFRESH_MS = 120;
    localparam int SLOW_REFRESH_CYC = SLOW_REFRESH_MS * (1000000 / CLK_NS);
    localparam int STRETCH_NS = 100;
    localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W = 24;
endpackage : ncr_pkg

// ### verilog/ncr_tick_gen.sv
`timescale 1ns/1ns
module ncr_tick_gen #(
    parameter int unsigned CW = 24,
    parameter int unsigned PERIOD = 1560
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } ncr_tick_s;

    ncr_tick_s s_r;
    ncr_tick_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == CW'(PERIOD - 1)) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;
endmodule : ncr_tick_gen

// ### verilog/ncr_range_hit.sv
`timescale 1ns/1ns
module ncr_range_hit #(
    parameter int unsigned AW = 12
) (
    input wire logic [AW-1:0] addr_i,
    input wire logic [AW-1:0] lo_i,
    input wire logic [AW-1:0] hi_i,
    input wire logic en_i,
    output logic hit_o
);
    // Inclusive on both ends; an inverted pair never hits
    assign hit_o = en_i && (addr_i >= lo_i) && (addr_i <= hi_i);
endmodule : ncr_range_hit

// ### verilog/ncr_noncache_ctrl.sv
`timescale 1ns/1ns
module ncr_noncache_ctrl #(
    parameter int unsigned SLOW_REFRESH_CYCLES = ncr_pkg::SLOW_REFRESH_CYC,
    parameter int unsigned REFRESH_CYCLES = ncr_pkg::REFRESH_CYC,
    parameter int unsigned STRETCH_CYCLES = ncr_pkg::STRETCH_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    input wire logic [23:0] mem_addr_i,
    input wire logic mem_start_i,
    input wire logic t2_end_i,
    input wire logic lookaside_ready_in_n_i,
    output logic cache_enable_out_n_o,
    output logic dram_cycle_go_o,
    input wire logic region1_en_i,
    input wire logic video_bios_nc_i,
    input wire logic video_bios_high_i,
    input wire logic sys_bios_nc_i,
    input wire logic core_strap_3v_i,
    output logic [1:0] core_drive_strength_o,
    input wire logic irq_req_i,
    output logic irq_cpu_o,
    input wire logic dma_cycle_start_i,
    output logic iochrdy_o,
    output logic iochrdy_oe_n_o,
    output logic refresh_req_o,
    output logic refresh_toggle_bit_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] upper;
        logic [11:0] lower;
        logic sref;
        logic gate_req;
        logic gate_act;
        logic snoop_en;
        logic [1:0] cdrv;
        logic [9:0] mask;
        logic [15:0] rdata;
        logic ken_n;
        logic cyc_open;
        logic lookaside_ready_in_seen;
        logic dram_go;
        logic irq_out;
        logic [7:0] stretch;
        logic chrdy_oe_n;
        logic refresh;
        logic toggle;
        logic [1:0] cdrv_out;
    } ncr_state_s;

    ncr_state_s s;
    ncr_state_s s_nxt;

    logic norm_tick;
    logic slow_tick;
    logic user_hit;
    logic vmem_hit;
    logic vbios_hit;
    logic sbios_hit;
    logic mask_hit;
    logic nc_now;
    logic [11:0] page;
    logic [5:0] blk_idx;
    logic [11:0] vb_lo;
    logic [11:0] vb_hi;

    // ----------------------------------------------------------------
    // Region decode
    // ----------------------------------------------------------------
    assign page = mem_addr_i[23:12];
    assign blk_idx = 6'(mem_addr_i[19:14] - ncr_pkg::MASK_BLK_FIRST);
    assign vb_lo = video_bios_high_i ? ncr_pkg::VBIOS_LO_E : ncr_pkg::VBIOS_LO_C;
    assign vb_hi = video_bios_high_i ? ncr_pkg::VBIOS_HI_E : ncr_pkg::VBIOS_HI_C;

    // user region, inverted limits disable it
    ncr_range_hit #(.AW(12)) u_user (
        .addr_i(page),
        .lo_i(s.lower),
        .hi_i(s.upper),
        .en_i(region1_en_i && !(s.upper < s.lower)),
        .hit_o(user_hit)
    );
    // Display memory is never cached; it changes behind the CPU
    ncr_range_hit #(.AW(12)) u_vmem (
        .addr_i(page),
        .lo_i(ncr_pkg::VMEM_LO),
        .hi_i(ncr_pkg::VMEM_HI),
        .en_i(1'b1),
        .hit_o(vmem_hit)
    );
    ncr_range_hit #(.AW(12)) u_vbios (
        .addr_i(page),
        .lo_i(vb_lo),
        .hi_i(vb_hi),
        .en_i(video_bios_nc_i),
        .hit_o(vbios_hit)
    );
    ncr_range_hit #(.AW(12)) u_sbios (
        .addr_i(page),
        .lo_i(ncr_pkg::SBIOS_LO),
        .hi_i(ncr_pkg::SBIOS_HI),
        .en_i(sys_bios_nc_i),
        .hit_o(sbios_hit)
    );

    // 16 KB block mask, zero blocks caching
    always_comb begin
        mask_hit = 1'b0;
        if (mem_addr_i[23:20] == 4'h0 && mem_addr_i[19:14] >= ncr_pkg::MASK_BLK_FIRST
                && mem_addr_i[19:14] <= ncr_pkg::MASK_BLK_LAST) begin
            mask_hit = !s.mask[blk_idx[3:0]];
        end
    end

    // any hit makes the access non-cachable
    assign nc_now = user_hit || vmem_hit || vbios_hit || sbios_hit || mask_hit;

    // ----------------------------------------------------------------
    // Refresh timers
    // ----------------------------------------------------------------
    ncr_tick_gen #(.CW(ncr_pkg::TIMER_W), .PERIOD(REFRESH_CYCLES)) u_norm (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_o(norm_tick)
    );
    ncr_tick_gen #(.CW(ncr_pkg::TIMER_W), .PERIOD(SLOW_REFRESH_CYCLES)) u_slow (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_o(slow_tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s;
        s_nxt.dram_go = 1'b0;
        s_nxt.rdata = 16'h0000;
        if (io_wr_i) begin
            if (io_addr_i == ncr_pkg::ADDR_UPPER) begin
                s_nxt.upper = io_wdata_i[15:ncr_pkg::BND_LSB];
                s_nxt.sref = io_wdata_i[ncr_pkg::SREF_BIT];
                s_nxt.gate_req = io_wdata_i[ncr_pkg::GATE_BIT];
                s_nxt.snoop_en = io_wdata_i[ncr_pkg::SNOOP_BIT];
            end else if (io_addr_i == ncr_pkg::ADDR_LOWER) begin
                s_nxt.lower = io_wdata_i[15:ncr_pkg::BND_LSB];
            end else if (io_addr_i == ncr_pkg::ADDR_MASK) begin
                s_nxt.cdrv = io_wdata_i[ncr_pkg::CDRV_LSB +: 2];
                s_nxt.mask = io_wdata_i[ncr_pkg::MASK_W-1:0];
            end
        end
        if (io_rd_i) begin
            if (io_addr_i == ncr_pkg::ADDR_UPPER) begin
                // pending while requested but not yet in force
                s_nxt.rdata = {s.upper, s.sref, s.gate_req, s.gate_req && !s.gate_act,
                    s.snoop_en};
            end else if (io_addr_i == ncr_pkg::ADDR_LOWER) begin
                s_nxt.rdata = {s.lower, 4'h0};
            end else if (io_addr_i == ncr_pkg::ADDR_MASK) begin
                s_nxt.rdata = {4'h0, s.cdrv, s.mask};
            end
        end
        // gate waits for an idle request line
        if (!s_nxt.gate_req) begin
            s_nxt.gate_act = 1'b0;
        end else if (!irq_req_i) begin
            s_nxt.gate_act = 1'b1;
        end
        s_nxt.irq_out = irq_req_i && !s_nxt.gate_act;
        // cache enable latched at cycle start
        if (mem_start_i) begin
            s_nxt.ken_n = nc_now;
            s_nxt.cyc_open = 1'b1;
            s_nxt.lookaside_ready_in_seen = !lookaside_ready_in_n_i;
        end else if (s.cyc_open && !lookaside_ready_in_n_i) begin
            s_nxt.lookaside_ready_in_seen = 1'b1;
        end
        // look-aside hit before T2 end kills the DRAM cycle
        if (s.cyc_open && t2_end_i && !mem_start_i) begin
            s_nxt.cyc_open = 1'b0;
            s_nxt.dram_go = !(s.lookaside_ready_in_seen || !lookaside_ready_in_n_i);
        end
        // hold IOCHRDY low for the snoop logic
        if (s.snoop_en && dma_cycle_start_i) begin
            s_nxt.stretch = 8'(STRETCH_CYCLES);
        end else if (s.stretch != 8'h00) begin
            s_nxt.stretch = s.stretch - 8'h01;
        end
        s_nxt.chrdy_oe_n = (s_nxt.stretch == 8'h00);
        // slow rate picks the long timer, toggle keeps normal rate
        s_nxt.refresh = s.sref ? slow_tick : norm_tick;
        if (norm_tick) begin
            s_nxt.toggle = !s.toggle;
        end
        // strength field only counts with a 3 V core
        s_nxt.cdrv_out = core_strap_3v_i ? s.cdrv : ncr_pkg::CDRV_DEFAULT;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // boundaries and mask zero: all ten mask blocks non-cachable; low and extended memory cache, except page 0 while region1_en_i is set
            s <= '0;
            s.upper <= ncr_pkg::BND_RST;
            s.lower <= ncr_pkg::BND_RST;
            s.mask <= ncr_pkg::MASK_RST;
            s.cdrv <= ncr_pkg::CDRV_RST;
            s.chrdy_oe_n <= 1'b1;
        end else begin
            s <= s_nxt;
        end
    end

    assign io_rdata_o = s.rdata;
    assign cache_enable_out_n_o = s.ken_n;
    assign dram_cycle_go_o = s.dram_go;
    assign core_drive_strength_o = s.cdrv_out;
    assign irq_cpu_o = s.irq_out;
    // Open drain: only ever pulls low
    assign iochrdy_o = 1'b0;
    assign iochrdy_oe_n_o = s.chrdy_oe_n;
    assign refresh_req_o = s.refresh;
    assign refresh_toggle_bit_o = s.toggle;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_mask_block_low: assert property (
        mem_start_i && mem_addr_i[23:14] == 10'h032 && !s.mask[0] && !user_hit
        |=> cache_enable_out_n_o)
        else $error("masked first block was cachable");
    a_mask_block_high: assert property (
        mem_start_i && mem_addr_i[23:14] == 10'h03B && s.mask[9] && !user_hit
        && !vbios_hit |=> !cache_enable_out_n_o)
        else $error("enabled last block was not cachable");
    a_user_region_hit: assert property (
        mem_start_i && region1_en_i && page >= s.lower && page <= s.upper
        |=> cache_enable_out_n_o)
        else $error("user region access was cachable");
    a_user_inverted: assert property (
        mem_start_i && s.upper < s.lower && mem_addr_i[23:20] != 4'h0
        |=> !cache_enable_out_n_o)
        else $error("inverted user region still active");
    a_lookaside_kill: assert property (
        s.cyc_open && !mem_start_i && t2_end_i && !lookaside_ready_in_n_i
        |=> !dram_cycle_go_o)
        else $error("memory cycle ran after look-aside ready");
    a_irq_gate_idle: assert property (
        s.gate_req && !irq_req_i ##1 s.gate_req |-> !irq_cpu_o ##1 !irq_cpu_o)
        else $error("gated interrupt reached the cpu");
    a_gate_status: assert property (
        io_wr_i && io_addr_i == ncr_pkg::ADDR_UPPER && io_wdata_i[2] && !s.gate_req
        && irq_req_i ##1 !io_wr_i && irq_req_i
        ##1 io_rd_i && io_addr_i == ncr_pkg::ADDR_UPPER && irq_req_i
        |=> io_rdata_o[1])
        else $error("pending gate not reported");
    a_snoop_stretch: assert property (
        s.snoop_en && dma_cycle_start_i |=> !iochrdy_oe_n_o [*8])
        else $error("snoop stretch too short");
    a_core_ignore: assert property (
        !core_strap_3v_i |=> core_drive_strength_o == 2'h0)
        else $error("strength applied with 5 V core");
    a_upper_readback: assert property (
        io_wr_i && io_addr_i == ncr_pkg::ADDR_UPPER ##1 !io_wr_i ##1 io_rd_i && !io_wr_i
        && io_addr_i == ncr_pkg::ADDR_UPPER
        |=> io_rdata_o[15:4] == $past(io_wdata_i[15:4], 3))
        else $error("upper boundary readback wrong");
    a_toggle_rate: assert property (
        norm_tick |=> refresh_toggle_bit_o != $past(refresh_toggle_bit_o))
        else $error("toggle bit missed a refresh period");
endmodule : ncr_noncache_ctrl

// ### verification/ncr_cache_partner.sv
`timescale 1ns/1ns
module ncr_cache_partner (
    input wire logic clock_i,
    input wire logic cache_enable_out_n_i,
    input wire logic dram_cycle_go_i,
    output logic [23:0] mem_addr_o,
    output logic mem_start_o,
    output logic t2_end_o,
    output logic lookaside_ready_in_n_o
);
    initial begin
        mem_addr_o = 24'h000000;
        mem_start_o = 1'b0;
        t2_end_o = 1'b0;
        lookaside_ready_in_n_o = 1'b1;
    end

    // ------------------------------------------------------------
    // One CPU memory cycle, T1 then T2 after lag cycles
    // ------------------------------------------------------------
    task automatic mem_cycle(input logic [23:0] a, input logic hit, input int lag,
                             output logic ken_n, output logic go);
        @(posedge clock_i);
        #1;
        mem_addr_o = a;
        mem_start_o = 1'b1;
        @(posedge clock_i);
        #1;
        mem_start_o = 1'b0;
        ken_n = cache_enable_out_n_i;
        repeat (lag) @(posedge clock_i);
        #1;
        t2_end_o = 1'b1;
        lookaside_ready_in_n_o = ~hit;
        @(posedge clock_i);
        #1;
        t2_end_o = 1'b0;
        go = dram_cycle_go_i;
        // Released lines: pull-up on ready, inverted address bus
        lookaside_ready_in_n_o = 1'b1;
        mem_addr_o = ~a;
    endtask : mem_cycle
endmodule : ncr_cache_partner

// ### verification/noncachable_region_control_tb.sv
`timescale 1ns/1ns
module noncachable_region_control_tb;
    localparam int REF_C = 20;
    localparam int SLOW_C = 200;
    localparam int STR_C = 10;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [9:0] mask;
        logic [11:0] lo;
        logic [11:0] hi;
        logic [3:0] ctl;
        logic [23:0] addr;
        logic hit;
        logic nc;
    } ncr_row_s;
    ncr_row_s rows [20] = '{
        '{10'h001, 12'h000, 12'h000, 4'h0, 24'h0C8000, 1'b0, 1'b0},
        '{10'h001, 12'h000, 12'h000, 4'h0, 24'h0CC000, 1'b1, 1'b1},
        '{10'h020, 12'h000, 12'h000, 4'h0, 24'h0DC000, 1'b0, 1'b0},
        '{10'h020, 12'h000, 12'h000, 4'h0, 24'h0D8000, 1'b0, 1'b1},
        '{10'h200, 12'h000, 12'h000, 4'h0, 24'h0EFFFF, 1'b0, 1'b0},
        '{10'h200, 12'h000, 12'h000, 4'h0, 24'h0E8000, 1'b1, 1'b1},
        '{10'h000, 12'h000, 12'h000, 4'h0, 24'h1C8000, 1'b0, 1'b0},
        '{10'h000, 12'h000, 12'h000, 4'h0, 24'h0CA000, 1'b0, 1'b1},
        '{10'h3FF, 12'h000, 12'h000, 4'h4, 24'h0C7FFF, 1'b0, 1'b1},
        '{10'h3FF, 12'h000, 12'h000, 4'h6, 24'h0E0000, 1'b0, 1'b1},
        '{10'h3FF, 12'h000, 12'h000, 4'h6, 24'h0C0000, 1'b0, 1'b0},
        '{10'h3FF, 12'h000, 12'h000, 4'h1, 24'h0FFFFF, 1'b0, 1'b1},
        '{10'h3FF, 12'h000, 12'h000, 4'h0, 24'h0F0000, 1'b0, 1'b0},
        '{10'h000, 12'h080, 12'h09F, 4'h8, 24'h080000, 1'b0, 1'b1},
        '{10'h000, 12'h080, 12'h09F, 4'h8, 24'h09FFFF, 1'b1, 1'b1},
        '{10'h000, 12'h080, 12'h09F, 4'h8, 24'h07FFFF, 1'b0, 1'b0},
        '{10'h000, 12'h080, 12'h09F, 4'h0, 24'h080000, 1'b0, 1'b0},
        '{10'h000, 12'hFFF, 12'hFFF, 4'h8, 24'hFFF000, 1'b0, 1'b1},
        '{10'h000, 12'h200, 12'h1FF, 4'h8, 24'h200000, 1'b0, 1'b0},
        '{10'h000, 12'h200, 12'h1FF, 4'h8, 24'h1FF000, 1'b0, 1'b0}};
    logic clock_i = 1'b0, rst_n_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000, io_wdata_i = 16'h0000, io_rdata_o, rd;
    logic [23:0] mem_addr_i;
    logic mem_start_i, t2_end_i, lookaside_ready_in_n_i, cache_enable_out_n_o;
    logic dram_cycle_go_o, ken_n, go, refresh_req_o, refresh_toggle_bit_o;
    logic region1_en_i = 1'b0, video_bios_nc_i = 1'b0, video_bios_high_i = 1'b0;
    logic sys_bios_nc_i = 1'b0, core_strap_3v_i = 1'b0, irq_req_i = 1'b0;
    logic dma_cycle_start_i = 1'b0, irq_cpu_o, iochrdy_o, iochrdy_oe_n_o;
    logic [1:0] core_drive_strength_o;
    int mismatches = 0, n_tests = 0, cycles = 0, n;

    ncr_noncache_ctrl #(.SLOW_REFRESH_CYCLES(SLOW_C), .REFRESH_CYCLES(REF_C),
        .STRETCH_CYCLES(STR_C)) dut (.clock_i, .rst_n_i, .io_addr_i, .io_wr_i,
        .io_rd_i, .io_wdata_i, .io_rdata_o, .mem_addr_i, .mem_start_i, .t2_end_i,
        .lookaside_ready_in_n_i, .cache_enable_out_n_o, .dram_cycle_go_o,
        .region1_en_i, .video_bios_nc_i, .video_bios_high_i, .sys_bios_nc_i,
        .core_strap_3v_i, .core_drive_strength_o, .irq_req_i, .irq_cpu_o,
        .dma_cycle_start_i, .iochrdy_o, .iochrdy_oe_n_o, .refresh_req_o,
        .refresh_toggle_bit_o);
    ncr_cache_partner u_cpu (.clock_i, .cache_enable_out_n_i(cache_enable_out_n_o),
        .dram_cycle_go_i(dram_cycle_go_o), .mem_addr_o(mem_addr_i),
        .mem_start_o(mem_start_i), .t2_end_o(t2_end_i),
        .lookaside_ready_in_n_o(lookaside_ready_in_n_i));

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic io_acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock_i);
        #1;
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = wr;
        io_rd_i = ~wr;
        @(posedge clock_i);
        #1;
        io_wr_i = 1'b0;
        io_rd_i = 1'b0;
        rd = io_rdata_o;
    endtask : io_acc
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask : step
    task automatic period(input logic tog, output int c);
        logic prev;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            do begin
                prev = refresh_toggle_bit_o;
                step(1);
                c++;
            end while ((tog ? refresh_toggle_bit_o === prev : refresh_req_o !== 1'b1)
                       && c < 500);
        end
    endtask : period
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        step(2);
        rst_n_i = 1'b1;
        for (int i = 0; i < 20; i++) begin
            io_acc(1'b1, ncr_pkg::ADDR_MASK, {6'h00, rows[i].mask});
            io_acc(1'b1, ncr_pkg::ADDR_LOWER, {rows[i].lo, 4'h0});
            io_acc(1'b1, ncr_pkg::ADDR_UPPER, {rows[i].hi, 4'h0});
            {region1_en_i, video_bios_nc_i, video_bios_high_i, sys_bios_nc_i} = rows[i].ctl;
            u_cpu.mem_cycle(rows[i].addr, rows[i].hit, i % 3, ken_n, go);
            check("cache_enable_out_n", ken_n, rows[i].nc);
            check("dram_cycle_go", go, !rows[i].hit);
        end
        $display("region table done");
        io_acc(1'b1, ncr_pkg::ADDR_UPPER, 16'hABCF);
        io_acc(1'b0, ncr_pkg::ADDR_UPPER, 16'h0000);
        check("upper reg", rd, 16'hABCD);
        io_acc(1'b1, ncr_pkg::ADDR_MASK, 16'h0C00);
        io_acc(1'b0, ncr_pkg::ADDR_MASK, 16'h0000);
        check("mask reg", rd, 16'h0C00);
        check("drive 5v", core_drive_strength_o, 2'h0);
        core_strap_3v_i = 1'b1;
        step(2);
        check("drive 3v", core_drive_strength_o, 2'h3);
        io_acc(1'b0, 16'h1234, 16'h0000);
        check("unmapped", rd, 16'h0000);
        $display("register test done");
        io_acc(1'b1, ncr_pkg::ADDR_UPPER, 16'h0000);
        irq_req_i = 1'b1;
        step(2);
        check("irq open", irq_cpu_o, 1'b1);
        io_acc(1'b1, ncr_pkg::ADDR_UPPER, 16'h0004);
        io_acc(1'b0, ncr_pkg::ADDR_UPPER, 16'h0000);
        check("gate pending", rd, 16'h0006);
        check("irq deferred", irq_cpu_o, 1'b1);
        irq_req_i = 1'b0;
        step(2);
        irq_req_i = 1'b1;
        step(2);
        check("irq gated", irq_cpu_o, 1'b0);
        io_acc(1'b0, ncr_pkg::ADDR_UPPER, 16'h0000);
        check("gate done", rd, 16'h0004);
        io_acc(1'b1, ncr_pkg::ADDR_UPPER, 16'h0000);
        step(1);
        check("irq reopened", irq_cpu_o, 1'b1);
        irq_req_i = 1'b0;
        $display("interrupt gate test done");
        for (int s = 0; s < 2; s++) begin
            io_acc(1'b1, ncr_pkg::ADDR_UPPER, {15'h0000, s[0]});
            dma_cycle_start_i = 1'b1;
            step(1);
            dma_cycle_start_i = 1'b0;
            n = 0;
            while (iochrdy_oe_n_o === 1'b0 && n < 50) begin
                n++;
                step(1);
            end
            check("stretch length", n, s * STR_C);
            check("iochrdy level", iochrdy_o, 1'b0);
        end
        $display("snoop stretch test done");
        period(1'b0, n);
        check("refresh period", n, REF_C);
        io_acc(1'b1, ncr_pkg::ADDR_UPPER, 16'h0008);
        period(1'b0, n);
        check("slow refresh period", n, SLOW_C);
        period(1'b1, n);
        check("toggle period", n, REF_C);
        $display("refresh test done");
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        check("ken after reset", cache_enable_out_n_o, 1'b0);
        io_acc(1'b0, ncr_pkg::ADDR_UPPER, 16'h0000);
        check("upper reset", rd, 16'h0000);
        io_acc(1'b0, ncr_pkg::ADDR_MASK, 16'h0000);
        check("mask reset", rd, 16'h0000);
        u_cpu.mem_cycle(24'h09FFFF, 1'b0, 1, ken_n, go);
        check("base memory", ken_n, 1'b0);
        u_cpu.mem_cycle(24'h100000, 1'b0, 0, ken_n, go);
        check("extended memory", ken_n, 1'b0);
        $display("reset test done");
        results();
    end
endmodule : noncachable_region_control_tb
